// ===== common/acsc_params.svh
// Offsets, field positions, reset values and counts of the clock select block
`ifndef ACSC_PARAMS_SVH
`define ACSC_PARAMS_SVH

// ==========================================================
// Register offsets
`define ACSC_OFS_CTRL0 8'h00
`define ACSC_OFS_CTRL1 8'h04
`define ACSC_OFS_ADC 8'h08
`define ACSC_OFS_STATUS 8'h0C

// ==========================================================
// Field positions
`define ACSC_CTRL0_PLL_PD 0
`define ACSC_CTRL0_MCLK_EN 1
`define ACSC_CTRL0_REF_LO 2
`define ACSC_CTRL0_REF_HI 4
`define ACSC_CTRL1_DIRECT 0
`define ACSC_ADC_RATE_LO 0
`define ACSC_ADC_RATE_HI 1
`define ACSC_ADC_HPF 2
`define ACSC_ADC_TDM 3
`define ACSC_ST_LOCK 0
`define ACSC_ST_INIT 1
`define ACSC_ST_DIRECT 2
`define ACSC_ST_ALONE 3
`define ACSC_ST_RATIO_LO 4
`define ACSC_ST_RATIO_HI 13
`define ACSC_ST_TDMCH_LO 14
`define ACSC_ST_TDMCH_HI 18

// ==========================================================
// Reset values
`define ACSC_RST_PLL_PD 1'b0
`define ACSC_RST_MCLK_EN 1'b0
`define ACSC_RST_REF 3'h0
`define ACSC_RST_DIRECT 1'b0
`define ACSC_RST_RATE 2'h0
`define ACSC_RST_HPF 1'b0
`define ACSC_RST_TDM 1'b0

// ==========================================================
// Multiples, counts and ratios
`define ACSC_MULT_256 10'h100
`define ACSC_MULT_384 10'h180
`define ACSC_MULT_512 10'h200
`define ACSC_MULT_768 10'h300
`define ACSC_CONV_PER_REF 26'h0000100
`define ACSC_LOCK_EDGES 5'h10
`define ACSC_INIT_MCLK_EDGES 9'h100
`define ACSC_CONV_PER_MOD 2'h2
`define ACSC_OSR 9'h080
`define ACSC_CONV_PER_SAMPLE 9'h100
`define ACSC_TDM_MAX_CH 5'h10
`define ACSC_STRAP_WAIT 3'h4

`endif

// ===== common/acsc_pkg.sv
// Types shared by the clock select block
package acsc_pkg;
    // ==========================================================
    // Rate modes and loop references
    typedef enum logic [1:0] {
        rate_48k,
        rate_96k,
        rate_192k
    } acsc_rate_type;

    typedef enum logic [2:0] {
        ref_mclk_256,
        ref_mclk_384,
        ref_mclk_512,
        ref_mclk_768,
        ref_frame,
        ref_aux_frame
    } acsc_ref_type;
endpackage

// ===== design/acsc_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module acsc_sync3 (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic pin_in,
    output logic pin_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    // ==========================================================
    // Chain; first stage feeds only the second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change counts once stages two and three agree
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            pin_q <= s3_q;
        end
    end
endmodule
`default_nettype wire

// ===== design/acsc_clk_gate.sv
// Glitch-free gate and source select for the converter clock tick
`timescale 1ns/1ps
`default_nettype none
module acsc_clk_gate (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic loop_tick,
    input wire logic direct_tick,
    input wire logic want_direct,
    input wire logic want_enable,
    output logic conv_tick,
    output logic direct_active
);
    logic en_q;

    // ==========================================================
    // Select and enable move only between ticks, so no partial tick escapes
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q <= 1'b0;
            direct_active <= 1'b0;
        end else if (!loop_tick && !direct_tick) begin
            en_q <= want_enable;
            direct_active <= want_direct;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_tick <= 1'b0;
        end else begin
            conv_tick <= en_q & (direct_active ? direct_tick : loop_tick);
        end
    end
endmodule
`default_nettype wire

// ===== design/acsc_top.sv
// Converter clock select, loop model, gating, APB registers and pin roles
//
// What this block does
// - Loop reference: frame, aux frame, or mclk multiples
// - Power-up default reference is mclk times 256
// - 96 kHz mode halves the effective ratio
// - 192 kHz mode quarters the effective ratio
// - Converters run from a 256 fs clock
// - Direct option bypasses loop with 512 fs mclk
// - Direct bypass never used in 192 kHz mode
// - Loop power-down bit stops the loop
// - Internal clock enable gates the converter clock
// - Reset leaves clock disabled until host or standalone strap enables
// - Selectable high-pass filter, cutoff tracks rate
// - Decimation oversampling ratio is 128 always
// - Rate modes of 48, 96 and 192 kHz
// - Stereo: two data pins, shared frame clocks
// - TDM carries up to 16 channels
// - Second data pin: pair two out, TDM in
// - First data pin: pair one or TDM stream
// - Standalone forces clock enable to one
// - Init of 256 mclk cycles after lock or direct source active
`include "acsc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module acsc_top (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_clock_in,
    output logic master_clock_out,
    input wire logic conv_frame_clock,
    input wire logic aux_frame_clock_pin,
    input wire logic ctrl_data_in,
    input wire logic ctrl_clock,
    input wire logic ctrl_latch,
    input wire logic pair1_bit,
    input wire logic pair2_bit,
    input wire logic tdm_stream_bit,
    output logic serial_out_first,
    output logic serial_out_second_out,
    output logic serial_out_second_oe,
    input wire logic serial_out_second_in,
    output logic tdm_chain_bit,
    output logic conv_tick,
    output logic mod_tick,
    output logic sample_tick,
    output logic hpf_enable,
    output logic init_done,
    output acsc_pkg::acsc_rate_type rate_mode
);
    import acsc_pkg::*;

    // ==========================================================
    // Pin synchronisers
    localparam int NPIN = 7;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_q;
    assign pin_raw = {serial_out_second_in, ctrl_latch, ctrl_clock, ctrl_data_in,
                      aux_frame_clock_pin, conv_frame_clock, master_clock_in};
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            acsc_sync3 u_sync (
                .clk(clk),
                .sys_rst(sys_rst),
                .pin_in(pin_raw[gi]),
                .pin_q(pin_q[gi])
            );
        end
    endgenerate

    logic [2:0] prev_q;
    logic mclk_edge;
    logic frame_edge;
    logic aux_edge;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_q <= 3'h0;
        end else begin
            prev_q <= pin_q[2:0];
        end
    end
    assign mclk_edge = pin_q[0] & ~prev_q[0];
    assign frame_edge = pin_q[1] & ~prev_q[1];
    assign aux_edge = pin_q[2] & ~prev_q[2];

    // ==========================================================
    // Registers
    logic pll_pd_q;
    logic mclk_en_q;
    acsc_ref_type ref_sel_q;
    logic direct_sel_q;
    acsc_rate_type rate_q;
    logic hpf_q;
    logic tdm_q;
    logic strap_done_q;
    logic standalone_q;
    logic [2:0] strap_wait_q;
    logic locked_q;
    logic direct_active;
    logic [9:0] eff_ratio_q;
    logic apb_wr;
    logic strap_set;
    assign apb_wr = psel & penable & pready & pwrite & ~pslverr & ~standalone_q;

    // Straps caught a few cycles after release, once synchronisers settle
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_wait_q <= 3'h0;
            strap_done_q <= 1'b0;
            standalone_q <= 1'b0;
        end else if (!strap_done_q) begin
            if (strap_wait_q == `ACSC_STRAP_WAIT) begin
                strap_done_q <= 1'b1;
                standalone_q <= ~pin_q[3] & ~pin_q[4] & ~pin_q[5];
            end else begin
                strap_wait_q <= strap_wait_q + 3'h1;
            end
        end
    end
    assign strap_set = ~strap_done_q & (strap_wait_q == `ACSC_STRAP_WAIT) &
                       ~pin_q[3] & ~pin_q[4] & ~pin_q[5];

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pll_pd_q <= `ACSC_RST_PLL_PD;
            mclk_en_q <= `ACSC_RST_MCLK_EN;
            ref_sel_q <= acsc_ref_type'(`ACSC_RST_REF);
        end else if (strap_set) begin
            mclk_en_q <= 1'b1;
        end else if (apb_wr && paddr == `ACSC_OFS_CTRL0) begin
            pll_pd_q <= pwdata[`ACSC_CTRL0_PLL_PD];
            mclk_en_q <= pwdata[`ACSC_CTRL0_MCLK_EN];
            // Unused reference codes keep the old choice
            if (pwdata[`ACSC_CTRL0_REF_HI:`ACSC_CTRL0_REF_LO] <= 3'h5) begin
                ref_sel_q <= acsc_ref_type'(pwdata[`ACSC_CTRL0_REF_HI:`ACSC_CTRL0_REF_LO]);
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            direct_sel_q <= `ACSC_RST_DIRECT;
        end else if (apb_wr && paddr == `ACSC_OFS_CTRL1) begin
            direct_sel_q <= pwdata[`ACSC_CTRL1_DIRECT];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_q <= acsc_rate_type'(`ACSC_RST_RATE);
            hpf_q <= `ACSC_RST_HPF;
            tdm_q <= `ACSC_RST_TDM;
        end else if (apb_wr && paddr == `ACSC_OFS_ADC) begin
            if (pwdata[`ACSC_ADC_RATE_HI:`ACSC_ADC_RATE_LO] != 2'h3) begin
                rate_q <= acsc_rate_type'(pwdata[`ACSC_ADC_RATE_HI:`ACSC_ADC_RATE_LO]);
            end
            hpf_q <= pwdata[`ACSC_ADC_HPF];
            tdm_q <= pwdata[`ACSC_ADC_TDM];
        end
    end

    // ==========================================================
    // APB slave, one wait-free access phase
    logic hit;
    assign hit = (paddr == `ACSC_OFS_CTRL0) || (paddr == `ACSC_OFS_CTRL1) ||
                 (paddr == `ACSC_OFS_ADC) || (paddr == `ACSC_OFS_STATUS);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit;
            prdata <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                if (paddr == `ACSC_OFS_CTRL0) begin
                    prdata[`ACSC_CTRL0_PLL_PD] <= pll_pd_q;
                    prdata[`ACSC_CTRL0_MCLK_EN] <= mclk_en_q;
                    prdata[`ACSC_CTRL0_REF_HI:`ACSC_CTRL0_REF_LO] <= ref_sel_q;
                end else if (paddr == `ACSC_OFS_CTRL1) begin
                    prdata[`ACSC_CTRL1_DIRECT] <= direct_sel_q;
                end else if (paddr == `ACSC_OFS_ADC) begin
                    prdata[`ACSC_ADC_RATE_HI:`ACSC_ADC_RATE_LO] <= rate_q;
                    prdata[`ACSC_ADC_HPF] <= hpf_q;
                    prdata[`ACSC_ADC_TDM] <= tdm_q;
                end else if (paddr == `ACSC_OFS_STATUS) begin
                    prdata[`ACSC_ST_LOCK] <= locked_q;
                    prdata[`ACSC_ST_INIT] <= init_done;
                    prdata[`ACSC_ST_DIRECT] <= direct_active;
                    prdata[`ACSC_ST_ALONE] <= standalone_q;
                    prdata[`ACSC_ST_RATIO_HI:`ACSC_ST_RATIO_LO] <= eff_ratio_q;
                    prdata[`ACSC_ST_TDMCH_HI:`ACSC_ST_TDMCH_LO] <= `ACSC_TDM_MAX_CH;
                end
            end
        end
    end

    // ==========================================================
    // Effective ratio: master clock stays fixed as the rate rises
    logic [9:0] mult;
    logic ref_is_mclk;
    logic ref_edge;
    always_comb begin
        case (ref_sel_q)
            ref_mclk_384: mult = `ACSC_MULT_384;
            ref_mclk_512: mult = `ACSC_MULT_512;
            ref_mclk_768: mult = `ACSC_MULT_768;
            default: mult = `ACSC_MULT_256;
        endcase
    end
    assign ref_is_mclk = (ref_sel_q != ref_frame) && (ref_sel_q != ref_aux_frame);
    assign ref_edge = ref_is_mclk ? mclk_edge :
                      (ref_sel_q == ref_frame) ? frame_edge : aux_edge;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            eff_ratio_q <= `ACSC_MULT_256;
        end else if (rate_q == rate_192k) begin
            eff_ratio_q <= mult >> 2;
        end else if (rate_q == rate_96k) begin
            eff_ratio_q <= mult >> 1;
        end else begin
            eff_ratio_q <= mult;
        end
    end

    // ==========================================================
    // Loop model: measure reference period, spread 256 ticks per frame
    logic [15:0] cnt_q;
    logic [15:0] period_q;
    logic [4:0] lock_cnt_q;
    logic [25:0] acc_q;
    logic [25:0] den;
    logic [25:0] acc_next;
    logic loop_tick;
    logic mode_chg;
    acsc_ref_type ref_prev_q;
    acsc_rate_type rate_prev_q;
    assign mode_chg = (ref_prev_q != ref_sel_q) || (rate_prev_q != rate_q);
    assign den = ref_is_mclk ? 26'(eff_ratio_q) * 26'(period_q) : {10'h000, period_q};
    assign acc_next = acc_q + `ACSC_CONV_PER_REF;
    assign loop_tick = locked_q && (acc_next >= den);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ref_prev_q <= acsc_ref_type'(`ACSC_RST_REF);
            rate_prev_q <= acsc_rate_type'(`ACSC_RST_RATE);
        end else begin
            ref_prev_q <= ref_sel_q;
            rate_prev_q <= rate_q;
        end
    end

    // Mode change drops lock; host is expected to cycle power-down too
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 16'h0000;
            period_q <= 16'h0000;
            lock_cnt_q <= 5'h00;
            locked_q <= 1'b0;
        end else if (pll_pd_q || mode_chg) begin
            cnt_q <= 16'h0000;
            lock_cnt_q <= 5'h00;
            locked_q <= 1'b0;
        end else if (ref_edge) begin
            cnt_q <= 16'h0000;
            period_q <= cnt_q + 16'h0001;
            if (lock_cnt_q == `ACSC_LOCK_EDGES) begin
                locked_q <= 1'b1;
            end else begin
                lock_cnt_q <= lock_cnt_q + 5'h01;
            end
        end else if (cnt_q != 16'hFFFF) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_q <= 26'h0000000;
        end else if (!locked_q) begin
            acc_q <= 26'h0000000;
        end else if (loop_tick) begin
            acc_q <= acc_next - den;
        end else begin
            acc_q <= acc_next;
        end
    end

    // ==========================================================
    // Direct 512 fs path: halve in 48 kHz, pass in 96 kHz
    logic div_q;
    logic direct_tick;
    logic want_direct;
    assign want_direct = direct_sel_q && (rate_q != rate_192k);
    assign direct_tick = mclk_edge && (rate_q == rate_96k || div_q) &&
                         (rate_q != rate_192k);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 1'b0;
        end else if (mclk_edge) begin
            div_q <= ~div_q;
        end
    end

    logic gate_tick;
    acsc_clk_gate u_gate (
        .clk(clk),
        .sys_rst(sys_rst),
        .loop_tick(loop_tick),
        .direct_tick(direct_tick),
        .want_direct(want_direct),
        .want_enable(mclk_en_q),
        .conv_tick(gate_tick),
        .direct_active(direct_active)
    );

    // ==========================================================
    // Initialisation after clock ready, then converter strobes
    logic clk_ready;
    logic [7:0] init_cnt_q;
    logic [0:0] mod_cnt_q;
    logic [7:0] smp_cnt_q;
    assign clk_ready = strap_done_q && (direct_active || locked_q);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            init_cnt_q <= 8'h00;
            init_done <= 1'b0;
        end else if (!clk_ready) begin
            init_cnt_q <= 8'h00;
            init_done <= 1'b0;
        end else if (mclk_edge && !init_done) begin
            init_cnt_q <= init_cnt_q + 8'h01;
            init_done <= (9'(init_cnt_q) == `ACSC_INIT_MCLK_EDGES - 9'h001);
        end
    end

    // Modulator at 128 fs, half the 256 fs converter clock
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            conv_tick <= 1'b0;
            mod_tick <= 1'b0;
            sample_tick <= 1'b0;
            mod_cnt_q <= 1'b0;
            smp_cnt_q <= 8'h00;
        end else begin
            conv_tick <= gate_tick & init_done;
            mod_tick <= 1'b0;
            sample_tick <= 1'b0;
            if (gate_tick && init_done) begin
                mod_cnt_q <= mod_cnt_q + 1'b1;
                smp_cnt_q <= smp_cnt_q + 8'h01;
                mod_tick <= mod_cnt_q;
                sample_tick <= (9'(smp_cnt_q) == `ACSC_CONV_PER_SAMPLE - 9'h001);
            end
        end
    end

    // ==========================================================
    // Pin roles and plain outputs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            serial_out_first <= 1'b0;
            serial_out_second_out <= 1'b0;
            serial_out_second_oe <= 1'b1;
            tdm_chain_bit <= 1'b0;
            master_clock_out <= 1'b0;
            hpf_enable <= `ACSC_RST_HPF;
            rate_mode <= rate_48k;
        end else begin
            serial_out_first <= tdm_q ? tdm_stream_bit : pair1_bit;
            serial_out_second_out <= tdm_q ? 1'b0 : pair2_bit;
            serial_out_second_oe <= ~tdm_q;
            tdm_chain_bit <= tdm_q & pin_q[6];
            master_clock_out <= pin_q[0];
            hpf_enable <= hpf_q;
            rate_mode <= rate_q;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_no_direct_192: assert property ((rate_q == rate_192k) [*4] |-> !direct_active)
        else $error("direct source active in 192 kHz mode");
    a_pd_unlocks: assert property (pll_pd_q |=> !locked_q && !loop_tick)
        else $error("loop running while powered down");
    a_gate_off: assert property (!mclk_en_q [*4] |-> !gate_tick)
        else $error("converter tick while clock disabled");
    a_enable_cause: assert property ($rose(mclk_en_q) |->
            $past(strap_set) || $past(apb_wr && paddr == `ACSC_OFS_CTRL0))
        else $error("clock enable set without cause");
    a_alone_force: assert property ($rose(strap_done_q) && standalone_q |-> mclk_en_q)
        else $error("standalone left clock disabled");
    a_ratio_96: assert property ((ref_sel_q == ref_mclk_384) && (rate_q == rate_96k)
            |=> eff_ratio_q == 10'h0C0)
        else $error("96 kHz ratio wrong");
    a_ratio_192: assert property ((ref_sel_q == ref_mclk_256) && (rate_q == rate_192k)
            |=> eff_ratio_q == 10'h040)
        else $error("192 kHz ratio wrong");
    a_init_len: assert property ($rose(init_done) |->
            $past(init_cnt_q) == 8'hFF && $past(clk_ready))
        else $error("init finished early");
    a_tdm_input: assert property (tdm_q ##1 tdm_q |-> !serial_out_second_oe)
        else $error("second data pin driven in TDM");
    a_no_tick_early: assert property (!init_done |=> !conv_tick)
        else $error("converter tick before init");
endmodule
`default_nettype wire

// ===== verification/acsc_clk_src.sv
// Master clock and frame clock source beside the block
`timescale 1ns/1ps
`default_nettype none
module acsc_clk_src (
    input wire logic run,
    input wire logic [7:0] half_ns,
    output logic mclk,
    output logic frame
);
    // ==========
    // Stable source, still while not running
    logic [6:0] div_q;
    initial begin
        mclk = 1'b0;
        frame = 1'b0;
        div_q = 7'h00;
        #1;
        forever begin
            #(half_ns);
            if (run) begin
                mclk = ~mclk;
                div_q = div_q + 7'h01;
                // Frame much slower than mclk
                if (div_q == 7'h00) frame = ~frame;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/adc_clock_select_control_tb.sv
// Self-checking bench for the converter clock select block
`timescale 1ns/1ps
`default_nettype none
module adc_clock_select_control_tb;
    import acsc_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, run = 1'b0;
    logic p1 = 1'b0, p2 = 1'b0, ts = 1'b0, s2i = 1'b0;
    logic [7:0] paddr = 8'h00, half_ns = 8'h14;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    logic pready, pslverr, er, mclk, frame, sof, s2o, s2oe, ct, mt, hpf, init_done, tc;
    acsc_rate_type rate_mode;
    int error_cnt = 0, compares = 0, n, cnt;
    acsc_clk_src i_acsc_clk_src (.run(run), .half_ns(half_ns), .mclk(mclk), .frame(frame));
    acsc_top i_acsc_top (.clk(clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_clock_in(mclk), .master_clock_out(), .conv_frame_clock(frame),
        .aux_frame_clock_pin(frame), .ctrl_data_in(1'b0), .ctrl_clock(1'b0), .ctrl_latch(1'b1),
        .pair1_bit(p1), .pair2_bit(p2), .tdm_stream_bit(ts), .serial_out_first(sof),
        .serial_out_second_out(s2o), .serial_out_second_oe(s2oe), .serial_out_second_in(s2i),
        .tdm_chain_bit(tc), .conv_tick(ct), .mod_tick(mt), .sample_tick(), .hpf_enable(hpf),
        .init_done(init_done), .rate_mode(rate_mode));
    initial forever #2.5 clk = ~clk;
    // ==========
    // Checks and verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        if (error_cnt == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    function automatic logic [9:0] exp_ratio(input int f, input int r);
        logic [9:0] m;
        m = (f == 0) ? 10'h100 : (f == 1) ? 10'h180 : (f == 2) ? 10'h200 : 10'h300;
        return m >> r;
    endfunction
    // ==========
    // Bus master, one word per transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            chk(32'h0, 32'h1);
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Polls status; bounded so a stuck bit ends the run
    task automatic wait_st(input int b, input logic val);
        int k;
        k = 0;
        do begin
            xfer(1'b0, 8'h0C, 32'h0);
            k++;
        end while (rd[b] !== val && k < 500);
        chk(rd[b], val);
        if (rd[b] !== val) print_verdict();
    endtask
    task automatic ticks;
        cnt = 0;
        n = 0;
        repeat (1024) begin
            @(negedge clk);
            cnt += ct;
            n += mt;
        end
    endtask
    task automatic pins(input logic tdm);
        xfer(1'b1, 8'h08, {28'h0, tdm, 3'h0});
        v = $urandom;
        @(posedge clk);
        ts <= v[0];
        p1 <= v[1];
        p2 <= v[2];
        s2i <= v[3];
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk(sof, tdm ? v[0] : v[1]);
        chk({s2oe, s2o, tc}, tdm ? {2'b00, v[3]} : {1'b1, v[2], 1'b0});
    endtask
    // ==========
    // Main sequence
    initial begin
        v = $urandom(30134);
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        xfer(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h0C, 32'h0);
        chk({rd[18:4], rd[3]}, {5'h10, 10'h100, 1'b0});
        xfer(1'b0, 8'h10, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        for (int r = 0; r < 3; r++) begin
            for (int f = 0; f < 6; f++) begin
                v = $urandom;
                xfer(1'b1, 8'h08, {29'h0, v[0], r[1:0]});
                xfer(1'b1, 8'h00, {27'h0, f[2:0], 2'b01});
                xfer(1'b0, 8'h00, 32'h0);
                chk(rd[4:2], f[2:0]);
                chk({hpf, rate_mode}, {v[0], r[1:0]});
                xfer(1'b0, 8'h0C, 32'h0);
                if (f < 4) chk(rd[13:4], exp_ratio(f, r));
            end
        end
        xfer(1'b1, 8'h00, 32'h19);
        xfer(1'b0, 8'h00, 32'h0);
        chk(rd[4:2], 3'h5);
        // Loop stays down until the source runs
        xfer(1'b1, 8'h08, 32'h0);
        xfer(1'b1, 8'h00, 32'h1);
        run <= 1'b1;
        xfer(1'b1, 8'h00, 32'h0);
        wait_st(0, 1'b1);
        xfer(1'b1, 8'h00, 32'h2);
        chk({init_done, ct}, 2'b00);
        n = 0;
        while (init_done !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk({init_done, n > 1500}, 2'b11);
        if (init_done !== 1'b1) print_verdict();
        ticks();
        chk({cnt >= 120, cnt <= 136, n * 2 >= cnt - 2, n * 2 <= cnt + 2}, 4'hF);
        xfer(1'b1, 8'h04, 32'h1);
        wait_st(2, 1'b1);
        ticks();
        chk({cnt >= 56, cnt <= 72}, 2'b11);
        xfer(1'b1, 8'h00, 32'h0);
        repeat (40) @(posedge clk);
        ticks();
        chk(cnt, 32'h0);
        xfer(1'b1, 8'h08, 32'h2);
        wait_st(2, 1'b0);
        xfer(1'b1, 8'h00, 32'h1);
        wait_st(0, 1'b0);
        for (int i = 0; i < 4; i++) pins(i[0]);
        print_verdict();
    end
endmodule
`default_nettype wire
